// [shared/atrs_cfg.svh]
`ifndef ATRS_CFG_SVH
`define ATRS_CFG_SVH

// ********************************************************
// Register indices (byte address = index * 4)
// ********************************************************
`define ATRS_IDX_RD_LO 16'h1805
`define ATRS_IDX_RD_HI 16'h1806
`define ATRS_IDX_CMD 16'h1807
`define ATRS_IDX_STS 16'h1808
`define ATRS_IDX_WR_LO 16'h1810
`define ATRS_IDX_WR_HI 16'h1811
`define ATRS_IDX_INGR_CFG 16'h1812

// ********************************************************
// Field positions
// ********************************************************
`define ATRS_HI_VALID 24
`define ATRS_HI_EOT 23
`define ATRS_HI_STATIC 22
`define ATRS_HI_FILTER 21
`define ATRS_HI_PRIO_MSB 20
`define ATRS_HI_PRIO_LSB 19
`define ATRS_HI_PORT_MSB 18
`define ATRS_HI_PORT_LSB 16
`define ATRS_STS_INIT_DONE 1
`define ATRS_STS_MAKE_PEND 0
`define ATRS_CMD_FIRST 0
`define ATRS_CMD_NEXT 1
`define ATRS_CMD_MAKE 2
`define ATRS_CFG_DPF 5

// ********************************************************
// Reset values
// ********************************************************
`define ATRS_RST_WORD 32'h0000_0000
`define ATRS_RST_CFG 32'h0000_0000

// ********************************************************
// Timing
// ********************************************************
`define ATRS_CLK_PERIOD_NS 8
`define ATRS_INIT_TIME_NS 20000
`define ATRS_INIT_CYCLES ((`ATRS_INIT_TIME_NS + `ATRS_CLK_PERIOD_NS - 1) / `ATRS_CLK_PERIOD_NS)
`define ATRS_AGE_TIME_S 300
`define ATRS_AGE_CYCLES (64'd1_000_000_000 * `ATRS_AGE_TIME_S / `ATRS_CLK_PERIOD_NS)
`define ATRS_TABLE_LAST 10'h3ff
`define ATRS_TABLE_DEPTH 1024

`endif

// [shared/atrs_pkg.sv]
package atrs_pkg;

	typedef struct packed {
		logic valid;
		logic stat;
		logic filt;
		logic [1:0] prio;
		logic [2:0] port;
		logic seen;
		logic [47:0] mac;
	} atrs_entry_t;

	typedef struct packed {
		logic [47:0] sa;
		logic [47:0] da;
	} atrs_pkt_t;

	typedef struct packed {
		logic drop;
		logic hit;
		logic prio_en;
		logic [1:0] prio;
		logic [2:0] ports;
	} atrs_pkt_res_t;

	typedef enum logic [3:0] {
		ATRS_ST_INIT,
		ATRS_ST_IDLE,
		ATRS_ST_SCAN_RD,
		ATRS_ST_SCAN_CHK,
		ATRS_ST_MAKE,
		ATRS_ST_DA_RD,
		ATRS_ST_DA_CHK,
		ATRS_ST_SA_RD,
		ATRS_ST_SA_CHK,
		ATRS_ST_AGE_RD,
		ATRS_ST_AGE_CHK
	} atrs_state_t;

endpackage

// [rtl/atrs_table_mem.sv]
`timescale 1ns/10ps
`include "atrs_cfg.svh"
module atrs_table_mem (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// Access port
	input wire logic we_in,
	input wire logic [9:0] addr_in,
	input wire atrs_pkg::atrs_entry_t wdata_in,
	output atrs_pkg::atrs_entry_t rdata_out
);
	import atrs_pkg::*;

	atrs_entry_t mem [`ATRS_TABLE_DEPTH];
	atrs_entry_t rdata_ff;

	// Array has no reset; the init sweep clears it
	always_ff @(posedge ref_clk_in) begin
		if (we_in) begin
			mem[addr_in] <= wdata_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= mem[addr_in];
		end
	end

	assign rdata_out = rdata_ff;
endmodule

// [rtl/atrs_top.sv]
// Overview of operation
// - Fetch command write clears entry-valid flag
// - Scan sets entry-valid on finding entry
// - Scan reaching top empty leaves valid clear
// - End-of-table flag set when scan reaches the last entry
// - Found entry loads both read-data words
// - Non-static entries age out after inactivity
// - Source address match marks entry active
// - Filter flag drops matching destination packets
// - Priority used only if static and configured
// - Three-bit port code maps to port sets
// - Upper word low half holds last MAC bits
// - Reset runs table init, then flag sets
// - Packets discarded while initialisation runs
// - Init flag reads zero after reset, then one
// - Insert-pending flag high while insert executes
// - Lower word holds first 32 MAC bits
`timescale 1ns/10ps
`include "atrs_cfg.svh"
module atrs_top #(
	parameter logic [39:0] AGE_CYCLES = 40'(`ATRS_AGE_CYCLES)
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// AXI4-Lite write
	input wire logic [31:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// AXI4-Lite read
	input wire logic [31:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Packet lookup
	input wire atrs_pkg::atrs_pkt_t pkt_in,
	input wire logic pkt_valid_in,
	output logic pkt_ready_out,
	output atrs_pkg::atrs_pkt_res_t pkt_res_out,
	output logic pkt_done_out
);
	import atrs_pkg::*;

	// ********************************************************
	// Functions
	// ********************************************************
	function automatic logic [9:0] hash_mac(input logic [47:0] mac);
		hash_mac = mac[9:0] ^ mac[19:10] ^ mac[29:20] ^ mac[39:30] ^ {2'b00, mac[47:40]};
	endfunction

	function automatic logic [2:0] port_mask(input logic [2:0] code);
		case (code)
			3'b000: port_mask = 3'b001;
			3'b001: port_mask = 3'b010;
			3'b010: port_mask = 3'b100;
			3'b100: port_mask = 3'b011;
			3'b101: port_mask = 3'b101;
			3'b110: port_mask = 3'b110;
			3'b111: port_mask = 3'b111;
			default: port_mask = 3'b000;
		endcase
	endfunction

	function automatic logic is_writable(input logic [16:0] idx);
		is_writable = idx == {1'b0, `ATRS_IDX_CMD} || idx == {1'b0, `ATRS_IDX_WR_LO} ||
			idx == {1'b0, `ATRS_IDX_WR_HI} || idx == {1'b0, `ATRS_IDX_INGR_CFG};
	endfunction

	function automatic logic [16:0] reg_index(input logic [31:0] addr);
		// Bit 16 flags an address outside the 18-bit window
		reg_index = {|addr[31:18], addr[17:2]};
	endfunction

	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		merge_strb = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge_strb[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
	endfunction

	// ********************************************************
	// State
	// ********************************************************
	atrs_state_t state_ff, nxt_state;
	logic [11:0] init_cnt_ff;
	logic init_done_ff;
	logic make_pend_ff, first_pend_ff, next_pend_ff;
	logic rd_valid_ff, rd_eot_ff;
	atrs_entry_t rd_entry_ff;
	logic [9:0] scan_idx_ff, age_idx_ff;
	logic [39:0] age_cnt_ff;
	logic age_req_ff;
	atrs_pkt_t pkt_ff;
	logic pkt_ready_ff, pkt_done_ff;
	atrs_pkt_res_t pkt_res_ff;
	logic [31:0] wr_lo_ff, wr_hi_ff, cfg_ff;
	logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
	logic [31:0] aw_addr_ff, w_data_ff, rdata_ff;
	logic [3:0] w_strb_ff;
	logic [1:0] bresp_ff, rresp_ff;

	// ********************************************************
	// Table memory
	// ********************************************************
	atrs_entry_t mem_rd, mem_wd, make_entry, age_entry, seen_entry;
	logic mem_we;
	logic [9:0] mem_addr;
	logic init_last, init_clear, scan_last, age_last;
	logic da_hit, sa_hit, age_kill;

	assign init_last = init_cnt_ff == 12'(`ATRS_INIT_CYCLES - 1);
	assign init_clear = init_cnt_ff < 12'(`ATRS_TABLE_DEPTH);
	assign scan_last = scan_idx_ff == `ATRS_TABLE_LAST;
	assign age_last = age_idx_ff == `ATRS_TABLE_LAST;
	assign da_hit = mem_rd.valid && mem_rd.mac == pkt_ff.da;
	assign sa_hit = mem_rd.valid && mem_rd.mac == pkt_ff.sa;
	assign age_kill = !mem_rd.stat && !mem_rd.seen;
	assign make_entry = '{valid: wr_hi_ff[`ATRS_HI_VALID], stat: wr_hi_ff[`ATRS_HI_STATIC],
		filt: wr_hi_ff[`ATRS_HI_FILTER],
		prio: wr_hi_ff[`ATRS_HI_PRIO_MSB:`ATRS_HI_PRIO_LSB],
		port: wr_hi_ff[`ATRS_HI_PORT_MSB:`ATRS_HI_PORT_LSB], seen: 1'b1,
		mac: {wr_hi_ff[15:0], wr_lo_ff}};
	// Aging clears valid unseen non-static entries and re-arms the activity mark of all other valid entries
	assign age_entry = age_kill ? '0 : atrs_entry_t'{valid: mem_rd.valid, stat: mem_rd.stat,
		filt: mem_rd.filt, prio: mem_rd.prio, port: mem_rd.port, seen: 1'b0, mac: mem_rd.mac};
	assign seen_entry = '{valid: mem_rd.valid, stat: mem_rd.stat, filt: mem_rd.filt,
		prio: mem_rd.prio, port: mem_rd.port, seen: 1'b1, mac: mem_rd.mac};

	assign mem_addr = (state_ff == ATRS_ST_INIT) ? init_cnt_ff[9:0] :
		(state_ff == ATRS_ST_SCAN_RD || state_ff == ATRS_ST_SCAN_CHK) ? scan_idx_ff :
		(state_ff == ATRS_ST_AGE_RD || state_ff == ATRS_ST_AGE_CHK) ? age_idx_ff :
		(state_ff == ATRS_ST_DA_RD || state_ff == ATRS_ST_DA_CHK) ? hash_mac(pkt_ff.da) :
		(state_ff == ATRS_ST_MAKE) ? hash_mac(make_entry.mac) : hash_mac(pkt_ff.sa);
	assign mem_we = (state_ff == ATRS_ST_INIT && init_clear) || (state_ff == ATRS_ST_MAKE) ||
		(state_ff == ATRS_ST_SA_CHK && sa_hit) || (state_ff == ATRS_ST_AGE_CHK && mem_rd.valid);
	assign mem_wd = (state_ff == ATRS_ST_INIT) ? '0 :
		(state_ff == ATRS_ST_MAKE) ? make_entry :
		(state_ff == ATRS_ST_AGE_CHK) ? age_entry : seen_entry;

	atrs_table_mem u_mem (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.we_in(mem_we),
		.addr_in(mem_addr),
		.wdata_in(mem_wd),
		.rdata_out(mem_rd)
	);

	// ********************************************************
	// Register bus
	// ********************************************************
	logic aw_take, w_take, ar_take, wr_fire, cmd_wr;
	logic [16:0] widx, ridx;
	logic wr_ok, rd_ok;
	logic [31:0] rd_hi_word, sts_word, rd_mux;

	assign aw_take = s_axi_awvalid_in && !aw_held_ff;
	assign w_take = s_axi_wvalid_in && !w_held_ff;
	assign ar_take = s_axi_arvalid_in && !rvalid_ff;
	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	assign widx = reg_index(aw_addr_ff);
	assign ridx = reg_index(s_axi_araddr_in);
	assign wr_ok = is_writable(widx);
	// Read decode must use the read address, never the last write address
	assign rd_ok = is_writable(ridx) || ridx == {1'b0, `ATRS_IDX_RD_LO} ||
		ridx == {1'b0, `ATRS_IDX_RD_HI} || ridx == {1'b0, `ATRS_IDX_STS};
	assign cmd_wr = wr_fire && widx == {1'b0, `ATRS_IDX_CMD} && w_strb_ff[0];
	assign rd_hi_word = {7'h00, rd_valid_ff, rd_eot_ff, rd_entry_ff.stat, rd_entry_ff.filt,
		rd_entry_ff.prio, rd_entry_ff.port, rd_entry_ff.mac[47:32]};
	assign sts_word = {30'h0000_0000, init_done_ff, make_pend_ff};
	assign rd_mux = (ridx == {1'b0, `ATRS_IDX_RD_LO}) ? rd_entry_ff.mac[31:0] :
		(ridx == {1'b0, `ATRS_IDX_RD_HI}) ? rd_hi_word :
		(ridx == {1'b0, `ATRS_IDX_STS}) ? sts_word :
		(ridx == {1'b0, `ATRS_IDX_WR_LO}) ? wr_lo_ff :
		(ridx == {1'b0, `ATRS_IDX_WR_HI}) ? (wr_hi_ff & 32'h01ff_ffff) :
		(ridx == {1'b0, `ATRS_IDX_INGR_CFG}) ? cfg_ff : 32'h0000_0000;

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			aw_addr_ff <= `ATRS_RST_WORD;
			w_data_ff <= `ATRS_RST_WORD;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'b00;
			rvalid_ff <= 1'b0;
			rresp_ff <= 2'b00;
			rdata_ff <= `ATRS_RST_WORD;
		end else begin
			aw_held_ff <= (aw_held_ff || aw_take) && !wr_fire;
			w_held_ff <= (w_held_ff || w_take) && !wr_fire;
			if (aw_take) begin
				aw_addr_ff <= s_axi_awaddr_in;
			end
			if (w_take) begin
				w_data_ff <= s_axi_wdata_in;
				w_strb_ff <= s_axi_wstrb_in;
			end
			if (wr_fire) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_ok ? 2'b00 : 2'b10;
			end else if (s_axi_bready_in) begin
				bvalid_ff <= 1'b0;
			end
			if (ar_take) begin
				rvalid_ff <= 1'b1;
				rresp_ff <= rd_ok ? 2'b00 : 2'b10;
				rdata_ff <= rd_ok ? rd_mux : 32'h0000_0000;
			end else if (s_axi_rready_in) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_lo_ff <= `ATRS_RST_WORD;
			wr_hi_ff <= `ATRS_RST_WORD;
			cfg_ff <= `ATRS_RST_CFG;
		end else if (wr_fire) begin
			if (widx == {1'b0, `ATRS_IDX_WR_LO}) begin
				wr_lo_ff <= merge_strb(wr_lo_ff, w_data_ff, w_strb_ff);
			end
			if (widx == {1'b0, `ATRS_IDX_WR_HI}) begin
				wr_hi_ff <= merge_strb(wr_hi_ff, w_data_ff, w_strb_ff) & 32'h01ff_ffff;
			end
			if (widx == {1'b0, `ATRS_IDX_INGR_CFG}) begin
				cfg_ff <= merge_strb(cfg_ff, w_data_ff, w_strb_ff) & 32'h0000_0020;
			end
		end
	end

	// ********************************************************
	// Sequencer
	// ********************************************************
	logic pkt_take;
	assign pkt_take = pkt_valid_in && pkt_ready_ff;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ATRS_ST_INIT: if (init_last) nxt_state = ATRS_ST_IDLE;
			ATRS_ST_IDLE: begin
				// Packets first: the ready already promised them a slot
				if (pkt_take) nxt_state = ATRS_ST_DA_RD;
				else if (make_pend_ff) nxt_state = ATRS_ST_MAKE;
				else if (first_pend_ff || next_pend_ff) nxt_state = ATRS_ST_SCAN_RD;
				else if (age_req_ff) nxt_state = ATRS_ST_AGE_RD;
			end
			ATRS_ST_SCAN_RD: nxt_state = ATRS_ST_SCAN_CHK;
			ATRS_ST_SCAN_CHK: begin
				if (mem_rd.valid || scan_last) nxt_state = ATRS_ST_IDLE;
				else nxt_state = ATRS_ST_SCAN_RD;
			end
			ATRS_ST_MAKE: nxt_state = ATRS_ST_IDLE;
			ATRS_ST_DA_RD: nxt_state = ATRS_ST_DA_CHK;
			ATRS_ST_DA_CHK: nxt_state = ATRS_ST_SA_RD;
			ATRS_ST_SA_RD: nxt_state = ATRS_ST_SA_CHK;
			ATRS_ST_SA_CHK: nxt_state = ATRS_ST_IDLE;
			ATRS_ST_AGE_RD: nxt_state = ATRS_ST_AGE_CHK;
			ATRS_ST_AGE_CHK: nxt_state = age_last ? ATRS_ST_IDLE : ATRS_ST_AGE_RD;
			default: nxt_state = ATRS_ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_ff <= ATRS_ST_INIT;
			init_cnt_ff <= 12'h000;
			init_done_ff <= 1'b0;
			age_cnt_ff <= 40'h00_0000_0000;
			age_req_ff <= 1'b0;
			age_idx_ff <= 10'h000;
		end else begin
			state_ff <= nxt_state;
			if (state_ff == ATRS_ST_INIT) begin
				init_cnt_ff <= init_cnt_ff + 12'h001;
			end
			if (state_ff == ATRS_ST_INIT && init_last) begin
				init_done_ff <= 1'b1;
			end
			// Sweep once per period, so an idle entry goes after one to two periods
			if (age_cnt_ff == AGE_CYCLES - 40'h00_0000_0001) begin
				age_cnt_ff <= 40'h00_0000_0000;
				age_req_ff <= 1'b1;
			end else begin
				age_cnt_ff <= age_cnt_ff + 40'h00_0000_0001;
				if (state_ff == ATRS_ST_AGE_RD) age_req_ff <= 1'b0;
			end
			if (state_ff == ATRS_ST_AGE_CHK) begin
				age_idx_ff <= age_idx_ff + 10'h001;
			end
		end
	end

	// ********************************************************
	// Commands and read-back
	// ********************************************************
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			make_pend_ff <= 1'b0;
			first_pend_ff <= 1'b0;
			next_pend_ff <= 1'b0;
			rd_valid_ff <= 1'b0;
			rd_eot_ff <= 1'b0;
			rd_entry_ff <= '0;
			scan_idx_ff <= 10'h000;
		end else begin
			if (cmd_wr && w_data_ff[`ATRS_CMD_MAKE]) begin
				make_pend_ff <= 1'b1;
			end else if (state_ff == ATRS_ST_MAKE) begin
				make_pend_ff <= 1'b0;
			end
			if (cmd_wr && (w_data_ff[`ATRS_CMD_FIRST] || w_data_ff[`ATRS_CMD_NEXT])) begin
				first_pend_ff <= w_data_ff[`ATRS_CMD_FIRST];
				next_pend_ff <= !w_data_ff[`ATRS_CMD_FIRST];
				rd_valid_ff <= 1'b0;
				if (w_data_ff[`ATRS_CMD_FIRST]) begin
					rd_eot_ff <= 1'b0;
				end
			end else if (state_ff == ATRS_ST_IDLE && nxt_state == ATRS_ST_SCAN_RD) begin
				first_pend_ff <= 1'b0;
				next_pend_ff <= 1'b0;
				if (first_pend_ff) begin
					scan_idx_ff <= 10'h000;
				end else begin
					scan_idx_ff <= scan_idx_ff + 10'h001;
				end
			end else if (state_ff == ATRS_ST_SCAN_CHK) begin
				if (mem_rd.valid) begin
					rd_valid_ff <= 1'b1;
					rd_entry_ff <= mem_rd;
				end
				if (scan_last) begin
					rd_eot_ff <= 1'b1;
				end else if (!mem_rd.valid) begin
					scan_idx_ff <= scan_idx_ff + 10'h001;
				end
			end
		end
	end

	// ********************************************************
	// Packet lookup
	// ********************************************************
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pkt_ff <= '0;
			pkt_ready_ff <= 1'b0;
			pkt_done_ff <= 1'b0;
			pkt_res_ff <= '0;
		end else begin
			pkt_ready_ff <= (nxt_state == ATRS_ST_IDLE || nxt_state == ATRS_ST_INIT) && !pkt_take;
			pkt_done_ff <= 1'b0;
			if (pkt_take) begin
				pkt_ff <= pkt_in;
			end
			if (pkt_take && state_ff == ATRS_ST_INIT) begin
				pkt_done_ff <= 1'b1;
				pkt_res_ff <= '{drop: 1'b1, hit: 1'b0, prio_en: 1'b0, prio: 2'b00,
					ports: 3'b000};
			end else if (state_ff == ATRS_ST_DA_CHK) begin
				pkt_done_ff <= 1'b1;
				pkt_res_ff <= '{drop: da_hit && mem_rd.filt, hit: da_hit,
					prio_en: da_hit && mem_rd.stat && cfg_ff[`ATRS_CFG_DPF],
					prio: mem_rd.prio, ports: da_hit ? port_mask(mem_rd.port) : 3'b111};
			end
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	assign s_axi_awready_out = !aw_held_ff;
	assign s_axi_wready_out = !w_held_ff;
	assign s_axi_bvalid_out = bvalid_ff;
	assign s_axi_bresp_out = bresp_ff;
	assign s_axi_arready_out = !rvalid_ff;
	assign s_axi_rvalid_out = rvalid_ff;
	assign s_axi_rresp_out = rresp_ff;
	assign s_axi_rdata_out = rdata_ff;
	assign pkt_ready_out = pkt_ready_ff;
	assign pkt_res_out = pkt_res_ff;
	assign pkt_done_out = pkt_done_ff;

	// ********************************************************
	// Assertions
	// ********************************************************
	sequence fetch_write_s;
		cmd_wr && (w_data_ff[`ATRS_CMD_FIRST] || w_data_ff[`ATRS_CMD_NEXT]);
	endsequence
	sequence scan_found_s;
		state_ff == ATRS_ST_SCAN_CHK && mem_rd.valid;
	endsequence

	AST_FETCH_CLEARS: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		fetch_write_s |=> !rd_valid_ff ##1 !rd_valid_ff)
		else $error("Fetch write did not clear valid");
	AST_VALID_CAUSE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		$rose(rd_valid_ff) |-> $past(state_ff) == ATRS_ST_SCAN_CHK && $past(mem_rd.valid))
		else $error("Valid rose without a found entry");
	AST_EMPTY_TOP: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		state_ff == ATRS_ST_SCAN_CHK && scan_last && !mem_rd.valid && !rd_valid_ff && !cmd_wr
		|=> rd_eot_ff && !rd_valid_ff)
		else $error("Empty scan end mis-flagged");
	AST_LOAD_FOUND: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		scan_found_s |=> rd_valid_ff && rd_entry_ff.mac == $past(mem_rd.mac)
		&& state_ff == ATRS_ST_IDLE)
		else $error("Found entry not loaded");
	AST_INIT_DONE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		$rose(init_done_ff) |-> $past(init_cnt_ff) == 12'(`ATRS_INIT_CYCLES - 1)
		&& state_ff == ATRS_ST_IDLE)
		else $error("Init done at wrong time");
	AST_INIT_DROP: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		pkt_take && !init_done_ff |=> pkt_done_ff && pkt_res_ff.drop)
		else $error("Packet not dropped during init");
	AST_FILTER: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		state_ff == ATRS_ST_DA_CHK && da_hit |=> pkt_done_ff
		&& pkt_res_ff.drop == $past(mem_rd.filt))
		else $error("Filter flag not applied");
	AST_PRIO_GATE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		pkt_done_ff && pkt_res_ff.prio_en |-> cfg_ff[`ATRS_CFG_DPF] && pkt_res_ff.hit)
		else $error("Priority used without enable");
	AST_MAKE_PEND: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		state_ff == ATRS_ST_MAKE && !cmd_wr |-> make_pend_ff ##1 !make_pend_ff)
		else $error("Insert pending flag wrong");
	AST_AGE_KILL: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		state_ff == ATRS_ST_AGE_CHK && mem_rd.valid && age_kill |-> mem_we && !mem_wd.valid)
		else $error("Idle entry not aged out");
	AST_SA_SEEN: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		state_ff == ATRS_ST_SA_CHK && sa_hit |-> mem_we && mem_wd.seen)
		else $error("Source match not recorded");
endmodule

// [dv/tb_top.sv]
`timescale 1ns/10ps
`include "atrs_cfg.svh"
module tb_top;
	import atrs_pkg::*;
	logic clk = 0;
	logic nrst = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d, lo;
	// Response ready lines stay high, so every answer is taken at the edge it is seen
	logic awv = 0, wv = 0, bready = 1, arv = 0, rready = 1, pkt_v = 0;
	logic awr, wrdy, bv, arr, rv, pkt_r, done;
	logic [1:0] bresp, rresp, r;
	atrs_pkt_t pkt = '0;
	atrs_pkt_res_t res, o;
	int num_errors = 0, n_compared = 0, cyc = 0, found = 0;
	// Hashes land far from index 0 so a fresh scan is still running when first read back
	logic [47:0] mac [3] = '{48'h0200_0000_0300, 48'h0100_0000_0200, 48'h0300_0000_0100};
	logic [6:0] fl [3] = '{7'h55, 7'h21, 7'h06};
	atrs_top #(.AGE_CYCLES(40'h07d0)) dut_u (.ref_clk_in(clk), .nrst_in(nrst),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rv), .s_axi_rready_in(rready), .pkt_in(pkt), .pkt_valid_in(pkt_v),
		.pkt_ready_out(pkt_r), .pkt_res_out(res), .pkt_done_out(done));
	initial begin
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			$display("[FAIL] %0t timeout", $time);
			end_sim;
		end
	end
	// ********************************************************
	// Access tasks
	// ********************************************************
	task end_sim;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task ck(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task axw(input logic [15:0] i, input logic [31:0] v, output logic [1:0] rs);
		logic a, w;
		a = 0;
		w = 0;
		awaddr <= {14'h0000, i, 2'h0};
		wdata <= v;
		awv <= 1;
		wv <= 1;
		do begin
			@(posedge clk);
			if (awr) a = 1;
			if (wrdy) w = 1;
			awv <= !a;
			wv <= !w;
		end while (!(a && w));
		do @(posedge clk); while (!bv);
		rs = bresp;
	endtask
	task axr(input logic [15:0] i, output logic [31:0] v, output logic [1:0] rs);
		araddr <= {14'h0000, i, 2'h0};
		arv <= 1;
		do @(posedge clk); while (!arr);
		arv <= 0;
		do @(posedge clk); while (!rv);
		v = rdata;
		rs = rresp;
	endtask
	task wr(input logic [15:0] i, input logic [31:0] v);
		axw(i, v, r);
		ck(r, 0);
	endtask
	task rd(input logic [15:0] i, output logic [31:0] v);
		axr(i, v, r);
		ck(r, 0);
	endtask
	task snd(input logic [47:0] sa, input logic [47:0] da);
		pkt <= '{sa: sa, da: da};
		pkt_v <= 1;
		do @(posedge clk); while (!pkt_r);
		pkt_v <= 0;
		do @(posedge clk); while (!done);
		o = res;
	endtask
	function logic [31:0] hw(int k);
		return {7'h00, 2'b10, fl[k], mac[k][47:32]};
	endfunction
	task mk(int k);
		wr(`ATRS_IDX_WR_LO, mac[k][31:0]);
		wr(`ATRS_IDX_WR_HI, hw(k));
		wr(`ATRS_IDX_CMD, 32'h0000_0004);
		// An insert can wait behind a full aging sweep
		for (int p = 0; p < 1500; p++) begin
			rd(`ATRS_IDX_STS, d);
			if (!d[0]) break;
		end
		ck(d, 32'h0000_0002);
	endtask
	// ********************************************************
	// Sequence
	// ********************************************************
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1;
		rd(`ATRS_IDX_STS, d);
		ck(d, 0);
		snd(48'h0, mac[0]);
		ck(o.drop, 1);
		for (int p = 0; p < 2000; p++) begin
			rd(`ATRS_IDX_STS, d);
			if (d[1]) break;
		end
		ck(d, 32'h0000_0002);
		for (int k = 0; k < 3; k++) mk(k);
		for (int f = 0; f < 5; f++) begin
			wr(`ATRS_IDX_CMD, f ? 32'h0000_0002 : 32'h0000_0001);
			rd(`ATRS_IDX_RD_HI, d);
			ck(d[24], 0);
			for (int p = 0; p < 1500 && !(d[24] | d[23]); p++) rd(`ATRS_IDX_RD_HI, d);
			ck(d & 32'hfe00_0000, 0);
			if (d[24]) begin
				rd(`ATRS_IDX_RD_LO, lo);
				for (int k = 0; k < 3; k++) if (lo === mac[k][31:0]) begin
					ck(d & 32'hff7f_ffff, hw(k));
					found++;
				end
			end
			if (d[23]) break;
		end
		ck(found, 3);
		ck(d[24:23], 2'b01);
		wr(`ATRS_IDX_INGR_CFG, 32'h0000_0020);
		snd(48'h0, mac[1]);
		ck(o, 8'hc2);
		snd(48'h0, mac[0]);
		ck(o, 8'h75);
		snd(48'h0, mac[2]);
		ck(o, 8'h46);
		snd(48'h0, 48'h0000_0000_0055);
		ck(o, 8'h07);
		wr(`ATRS_IDX_INGR_CFG, 32'h0000_0000);
		snd(48'h0, mac[0]);
		ck(o.prio_en, 0);
		// Only the third entry keeps seeing its source address while aging runs
		for (int t = 0; t < 6; t++) begin
			snd(mac[2], 48'h0000_0000_0055);
			repeat (900) @(posedge clk);
		end
		snd(48'h0, mac[1]);
		ck(o.hit, 0);
		snd(48'h0, mac[2]);
		ck(o.hit, 1);
		snd(48'h0, mac[0]);
		ck(o.hit, 1);
		axr(16'h1900, d, r);
		ck(d, 0);
		ck(r, 2'b10);
		axw(16'h1900, 32'hffff_ffff, r);
		ck(r, 2'b10);
		end_sim;
	end
endmodule
